// [hw/boot_map_pkg.sv]
// constants and types for the program-space boot map decoder
package boot_map_pkg;
  localparam int ADDR_W = 21;
  localparam logic [20:0] RESET_FETCH_INT = 21'h040000;
  localparam logic [20:0] WDOG_FETCH_INT = 21'h040002;
  localparam logic [20:0] RESET_FETCH_EXT16 = 21'h000000;
  localparam logic [20:0] WDOG_FETCH_EXT16 = 21'h000002;
  localparam logic [20:0] LOW_FLASH_END = 21'h00FFFF;
  localparam logic [20:0] FLASH_END = 21'h03FFFF;
  localparam logic [20:0] BOOT_BASE = 21'h040000;
  localparam logic [20:0] BOOT_END = 21'h043FFF;
  localparam logic [20:0] PRAM_BASE = 21'h04F800;
  localparam logic [20:0] PRAM_END = 21'h04FFFF;
  localparam logic [20:0] REACH16_END = 21'h00FFFF;
  localparam logic [20:0] REACH20_END = 21'h0FFFFF;
  localparam logic [20:0] MAP_END = 21'h1FFFFF;
  localparam logic [20:0] FLASH_BLK1_BASE = 21'h020000;
  localparam int EXT_ADDR_LINES_BOOT = 18;

  typedef enum logic [4:0] {
    TGT_NONE  = 5'h01,
    TGT_FLASH = 5'h02,
    TGT_BOOT  = 5'h04,
    TGT_PRAM  = 5'h08,
    TGT_EXT   = 5'h10
  } target_e;

  typedef struct packed {
    logic flash0_sel;
    logic flash1_sel;
    logic boot_sel;
    logic pram_sel;
    logic ext_sel;
  } mem_sel_s;

  typedef struct packed {
    logic layout_select_bit;
    logic secured_at_boot_flag;
    logic wide_addr;
  } mode_s;
endpackage : boot_map_pkg

// [hw/program_space_boot_map_decoder.sv]
// program-space memory map selection and address decoding
// Behaviour
// - layout bit 0 selects internal map; low ranges served by on-chip flash.
// - layout bit 1 selects external map unless secured flag was 0 at reset.
// - out of reset chip select zero is program strobe, one is data strobe.
// - wide strap high at reset enables address bits 19 to 16.
// - external boot needs eighteen address lines to shadow first 256K.
// - addresses from 0x100000 up reach external only after extra pins configured.
// - strap low gives 16-bit external bus, high gives 20-bit bus.
// - internal boot maps boot flash 0x040000-0x043FFF, fetches 0x040000 and 0x040002.
// - external 16-bit boot puts 0x000000-0x00FFFF external, fetches at 0 and 2.
// - external 16-bit boot keeps boot flash mapped but not fetched from.
// - external 20-bit boot sends boot flash range external, fetches 0x040000/2.
// - secured flash never allows external boot.
// - external memory beyond reset reach stays blocked until pins reconfigured.
// - program flash is two independent blocks with separate erase.
// - strap capture after reset release loads layout bit from boot strap ANDed with security state, secured flag from security state.
// - secured flag captured only at reset; later writes or changes ignored.
`timescale 1ns/10ps
module program_space_boot_map_decoder
  import boot_map_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic external_boot_strap,
  input wire logic wide_addr_strap,
  input wire logic flash_secure_n,
  input wire logic layout_wr,
  input wire logic layout_wdata,
  input wire logic secured_flag_wr,
  input wire logic secured_flag_wdata,
  input wire logic high_pins_en,
  input wire logic [20:0] prog_addr,
  input wire logic prog_req,
  output logic layout_select_bit,
  output logic secured_at_boot_flag,
  output logic wide_addr_q,
  output logic [20:0] reset_fetch_addr,
  output logic [20:0] watchdog_reset_addr,
  output logic [3:0] ext_addr_hi_en,
  output logic [3:0] ext_addr_top_en,
  output logic chip_sel_zero_is_program_strobe,
  output logic chip_sel_one_is_data_strobe,
  output mem_sel_s mem_sel,
  output logic chip_sel_zero_n,
  output logic [20:0] ext_addr_q
);
  logic [1:0] boot_sync_q;
  logic [1:0] wide_sync_q;
  logic [1:0] sec_sync_q;
  logic [1:0] hipin_sync_q;
  logic straps_taken_q;
  logic [1:0] settle_q;
  logic layout_q;
  logic secured_q;
  logic wide_q;
  logic sel_valid_q;
  target_e tgt;
  mem_sel_s sel_d;
  mem_sel_s sel_q;
  logic ext_mode;
  logic hi_pins;

  function automatic logic in_range(input logic [20:0] a, input logic [20:0] lo,
                                    input logic [20:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // two-flop synchronisers for pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_sync_q <= 2'h0;
      wide_sync_q <= 2'h0;
      sec_sync_q <= 2'h0;
      hipin_sync_q <= 2'h0;
    end else if (clk_en) begin
      boot_sync_q <= {boot_sync_q[0], external_boot_strap};
      wide_sync_q <= {wide_sync_q[0], wide_addr_strap};
      sec_sync_q <= {sec_sync_q[0], flash_secure_n};
      hipin_sync_q <= {hipin_sync_q[0], high_pins_en};
    end
  end

  // strap capture after reset release, then software writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      straps_taken_q <= 1'b0;
      settle_q <= 2'h0;
      layout_q <= 1'b0;
      secured_q <= 1'b0;
      wide_q <= 1'b0;
    end else if (clk_en) begin
      settle_q <= {settle_q[0], 1'b1};
      if (!straps_taken_q && settle_q[1]) begin
        straps_taken_q <= 1'b1;
        secured_q <= sec_sync_q[1];
        layout_q <= boot_sync_q[1] & sec_sync_q[1];
        wide_q <= wide_sync_q[1];
      end else if (straps_taken_q && layout_wr && secured_q) begin
        layout_q <= layout_wdata;
      end
    end
  end

  assign layout_select_bit = layout_q;
  assign secured_at_boot_flag = secured_q;
  assign wide_addr_q = wide_q;
  assign ext_mode = layout_q & secured_q;
  assign hi_pins = hipin_sync_q[1];

  // reset and watchdog fetch locations
  assign reset_fetch_addr = (ext_mode && !wide_q) ? RESET_FETCH_EXT16 : RESET_FETCH_INT;
  assign watchdog_reset_addr = (ext_mode && !wide_q) ? WDOG_FETCH_EXT16 : WDOG_FETCH_INT;

  assign ext_addr_hi_en = {4{wide_q}};
  assign ext_addr_top_en = {4{hi_pins}};
  assign chip_sel_zero_is_program_strobe = 1'b1;
  assign chip_sel_one_is_data_strobe = 1'b1;

  // address range decode
  always_comb begin
    tgt = TGT_NONE;
    if (in_range(prog_addr, PRAM_BASE, PRAM_END)) begin
      tgt = TGT_PRAM;
    end else if (in_range(prog_addr, BOOT_BASE, BOOT_END)) begin
      tgt = (ext_mode && wide_q) ? TGT_EXT : TGT_BOOT;
    end else if (prog_addr <= LOW_FLASH_END) begin
      tgt = ext_mode ? TGT_EXT : TGT_FLASH;
    end else if (prog_addr <= FLASH_END) begin
      tgt = TGT_FLASH;
    end else if (prog_addr > PRAM_END && prog_addr <= REACH20_END) begin
      tgt = (hi_pins || (ext_mode && wide_q)) ? TGT_EXT : TGT_NONE;
    end else if (prog_addr > REACH20_END) begin
      tgt = hi_pins ? TGT_EXT : TGT_NONE;
    end
  end

  assign sel_d.flash0_sel = prog_req && tgt == TGT_FLASH && prog_addr < FLASH_BLK1_BASE;
  assign sel_d.flash1_sel = prog_req && tgt == TGT_FLASH && prog_addr >= FLASH_BLK1_BASE;
  assign sel_d.boot_sel = prog_req && tgt == TGT_BOOT;
  assign sel_d.pram_sel = prog_req && tgt == TGT_PRAM;
  assign sel_d.ext_sel = prog_req && tgt == TGT_EXT;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= '0;
      ext_addr_q <= 21'h000000;
      sel_valid_q <= 1'b0;
    end else if (clk_en) begin
      sel_q <= sel_d;
      sel_valid_q <= prog_req;
      ext_addr_q <= sel_d.ext_sel ? prog_addr : 21'h000000;
    end
  end

  assign mem_sel = sel_q;
  assign chip_sel_zero_n = ~sel_q.ext_sel;

  property p_secure_blocks_ext;
    @(posedge sys_clk) disable iff (!rst_n)
      (straps_taken_q && !secured_q) |-> !layout_q;
  endproperty
  a_secure_blocks_ext: assert property (p_secure_blocks_ext) else $error("ext map while secured");

  property p_flag_stable;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(straps_taken_q) |-> $stable(secured_q);
  endproperty
  a_flag_stable: assert property (p_flag_stable) else $error("secured flag changed");

  property p_layout_locked;
    @(posedge sys_clk) disable iff (!rst_n)
      (straps_taken_q && !secured_q && layout_wr && clk_en) |=> !layout_q;
  endproperty
  a_layout_locked: assert property (p_layout_locked) else $error("layout changed while locked");

  property p_reserved_none;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && prog_req && prog_addr > BOOT_END && prog_addr < PRAM_BASE) |=> (sel_q == '0);
  endproperty
  a_reserved_none: assert property (p_reserved_none) else $error("reserved range selected");

  property p_pram;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && prog_req && prog_addr >= PRAM_BASE && prog_addr <= PRAM_END) |=> sel_q.pram_sel;
  endproperty
  a_pram: assert property (p_pram) else $error("program ram not selected");

  property p_internal_low;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && prog_req && !layout_q && prog_addr <= LOW_FLASH_END) |=> sel_q.flash0_sel;
  endproperty
  a_internal_low: assert property (p_internal_low) else $error("low range not flash");

  property p_high_blocked;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && prog_req && !hi_pins && prog_addr > REACH20_END) |=> !sel_q.ext_sel;
  endproperty
  a_high_blocked: assert property (p_high_blocked) else $error("high range reached");

  property p_int_boot_fetch;
    @(posedge sys_clk) disable iff (!rst_n)
      !layout_q |-> (reset_fetch_addr == RESET_FETCH_INT && watchdog_reset_addr == WDOG_FETCH_INT);
  endproperty
  a_int_boot_fetch: assert property (p_int_boot_fetch) else $error("bad internal fetch");

  property p_cs_follows;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && prog_req && ext_mode && wide_q && prog_addr >= BOOT_BASE
       && prog_addr <= BOOT_END) |=> !chip_sel_zero_n;
  endproperty
  a_cs_follows: assert property (p_cs_follows) else $error("boot range not external");

  property p_strap_capture;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(straps_taken_q) |-> (secured_q == $past(sec_sync_q[1])
       && layout_q == ($past(boot_sync_q[1]) & $past(sec_sync_q[1])));
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("strap capture wrong");

  property p_ext16_low;
    @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && prog_req && ext_mode && !wide_q && prog_addr <= LOW_FLASH_END) |=> !chip_sel_zero_n;
  endproperty
  a_ext16_low: assert property (p_ext16_low) else $error("low range not external");

  property p_one_target;
    @(posedge sys_clk) disable iff (!rst_n)
      sel_valid_q |-> $onehot0(sel_q);
  endproperty
  a_one_target: assert property (p_one_target) else $error("several targets selected");
endmodule : program_space_boot_map_decoder

// [tb/ext_prog_mem.sv]
// external program memory model on the chip-select zero strobe
`timescale 1ns/10ps
module ext_prog_mem (
  input wire logic sys_clk,
  input wire logic chip_sel_zero_n,
  input wire logic [20:0] ext_addr_q,
  output logic [15:0] rd_data,
  output int hits
);
  initial hits = 0;
  initial rd_data = 16'hFFFF;
  always @(posedge sys_clk) begin
    if (chip_sel_zero_n === 1'b0) begin
      hits <= hits + 1;
      rd_data <= ext_addr_q[15:0] ^ 16'hA5C3;
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule : ext_prog_mem

// [tb/program_space_boot_map_decoder_test.sv]
// map decoder testbench with queued expectations
`timescale 1ns/10ps
module program_space_boot_map_decoder_test;
  import boot_map_pkg::*;
  logic sys_clk = 0, rst_n = 0, ebs = 0, was = 0, fsn = 1, lwr = 0, lwd = 0, swr = 0, swd = 0;
  logic hpe = 0, prog_req = 0, lay_q, sec_q, wide_q, cs0_n, cs0p, cs1d;
  logic [20:0] prog_addr = 21'h000000, rfa, wfa, ext_addr_q;
  logic [3:0] hi_en, top_en;
  mem_sel_s mem_sel;
  logic [25:0] q[$];
  logic [25:0] ev;
  logic [31:0] rs = 32'h0000002F;
  logic lay = 0, wid = 0, hp = 0, tk = 0;
  int err_count = 0, check_count = 0, exp_hits = 0, hits;
  program_space_boot_map_decoder uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .external_boot_strap(ebs), .wide_addr_strap(was), .flash_secure_n(fsn), .layout_wr(lwr),
    .layout_wdata(lwd), .secured_flag_wr(swr), .secured_flag_wdata(swd), .high_pins_en(hpe),
    .prog_addr(prog_addr), .prog_req(prog_req), .layout_select_bit(lay_q),
    .secured_at_boot_flag(sec_q), .wide_addr_q(wide_q), .reset_fetch_addr(rfa),
    .watchdog_reset_addr(wfa), .ext_addr_hi_en(hi_en), .ext_addr_top_en(top_en),
    .chip_sel_zero_is_program_strobe(cs0p), .chip_sel_one_is_data_strobe(cs1d),
    .mem_sel(mem_sel), .chip_sel_zero_n(cs0_n), .ext_addr_q(ext_addr_q));
  ext_prog_mem mem (.sys_clk(sys_clk), .chip_sel_zero_n(cs0_n), .ext_addr_q(ext_addr_q),
    .rd_data(), .hits(hits));
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xorshift(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xorshift
  function automatic logic [25:0] expv(logic [20:0] a);
    logic [4:0] s;
    if (a >= 21'h04F800 && a <= 21'h04FFFF) s = 5'h02;
    else if (a >= 21'h044000 && a < 21'h050000) s = 5'h00;
    else if (a >= 21'h100000) s = hp ? 5'h01 : 5'h00;
    else if (a >= 21'h050000) s = (hp || (lay && wid)) ? 5'h01 : 5'h00;
    else if (a >= 21'h040000) s = (lay && wid) ? 5'h01 : 5'h04;
    else if (a < 21'h010000 && lay) s = 5'h01;
    else s = (a < 21'h020000) ? 5'h10 : 5'h08;
    return {s, s[0] ? a : 21'h000000};
  endfunction : expv
  task automatic chk(string n, logic [20:0] e, logic [20:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  always @(negedge sys_clk) begin
    if (tk) begin
      ev = q.pop_front();
      chk("mem_sel", {16'h0000, ev[25:21]}, {16'h0000, mem_sel});
      chk("chip_sel_zero_n", {20'h00000, ~ev[21]}, {20'h00000, cs0_n});
      chk("ext_addr_q", ev[20:0], ext_addr_q);
    end
    tk = prog_req;
  end
  task automatic idle(int n);
    repeat (n) @(posedge sys_clk) #1 prog_req = 0;
  endtask : idle
  task automatic acc(logic [20:0] a);
    @(posedge sys_clk) #1;
    prog_req = 1;
    prog_addr = a;
    q.push_back(expv(a));
    if (expv(a) & 26'h0200000) exp_hits++;
  endtask : acc
  task automatic sweep(int n);
    logic [20:0] b[17] = '{21'h0, 21'hFFFF, 21'h10000, 21'h1FFFF, 21'h20000, 21'h3FFFF,
      21'h40000, 21'h40002, 21'h43FFF, 21'h44000, 21'h4F7FF, 21'h4F800, 21'h4FFFF,
      21'h50000, 21'hFFFFF, 21'h100000, 21'h1FFFFF};
    logic [20:0] a;
    for (int i = 0; i < 17 + n; i++) begin
      rs = xorshift(rs);
      a = (i < 17) ? b[i] : rs[20:0];
      acc((lay && wid && a < 21'h040000) ? (a | 21'h040000) : a);
    end
    idle(3);
  endtask : sweep
  task automatic rst(logic e, logic w, logic s);
    if (rst_n) idle(2);
    {ebs, was, fsn, hpe, hp} = {e, w, s, 2'b00};
    rst_n = 0;
    idle(4);
    rst_n = 1;
    idle(5);
    lay = e & s;
    wid = w;
    chk("layout", {20'h0, lay}, {20'h0, lay_q});
    chk("secured", {20'h0, s}, {20'h0, sec_q});
    chk("wide", {17'h0, {4{w}}}, {17'h0, hi_en});
    chk("fetch", (lay && !w) ? 21'h0 : 21'h40000, rfa);
    chk("wdog", (lay && !w) ? 21'h2 : 21'h40002, wfa);
    chk("strobes", 21'h3, {19'h0, cs0p, cs1d});
    chk("top_en", 21'h0, {17'h0, top_en});
  endtask : rst
  task automatic pins_on();
    hpe = 1;
    idle(4);
    hp = 1;
    sweep(40);
  endtask : pins_on
  task automatic wr_layout(logic v);
    @(posedge sys_clk) #1 {lwr, lwd, swr, swd} = {1'b1, v, 2'b11};
    @(posedge sys_clk) #1 {lwr, swr} = 2'b00;
    idle(3);
  endtask : wr_layout
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    #300000;
    err_count++;
    final_report();
  end
  initial begin
    rst(0, 0, 1);
    sweep(40);
    pins_on();
    wr_layout(1);
    lay = 1;
    chk("layout", 21'h1, {20'h0, lay_q});
    chk("fetch", 21'h0, rfa);
    sweep(10);
    $display("test internal map done");
    rst(1, 0, 1);
    sweep(40);
    wr_layout(0);
    lay = 0;
    chk("layout", 21'h0, {20'h0, lay_q});
    sweep(10);
    $display("test external 16-bit map done");
    rst(1, 1, 1);
    sweep(40);
    pins_on();
    $display("test external 20-bit map done");
    rst(1, 0, 0);
    wr_layout(1);
    chk("layout", 21'h0, {20'h0, lay_q});
    chk("secured", 21'h0, {20'h0, sec_q});
    sweep(20);
    $display("test secured boot done");
    idle(3);
    chk("ext hits", exp_hits[20:0], hits[20:0]);
    final_report();
  end
endmodule : program_space_boot_map_decoder_test
